/* File: hdl/upic_top.sv */
// module: cpu port, status, modem pins and serial line of the serial controller
// Function
// - reset clears mode, command, status and stops all activity
// - stay idle until the command word is written
// - direction low reads, high writes
// - chip select low performs access; high releases data bus
// - data bus eight bits, bit zero least significant
// - transmit free output is inverse of status bit zero, tx enable gated
// - receive full output inverse of status bit one, cleared by read or disable
// - empty/change output low on tx empty or modem input change
// - status read releases empty/change unless tx empty persists until load
// - baud generator clock feeds internal generator, unused with external clocks
// - external receive clock 1x (multiplier unused), sample data on rising edge
// - internal receive clock: pin is clock output or break flag
// - external transmit clock 1x (multiplier unused), output changes on falling edge
// - internal transmit clock: pin is clock output or jam sync input
// - mark high, space low; line held at mark when tx disabled
// - status bit seven inverse of set ready; change flags when enabled
// - receiver runs only with carrier low; bit six inverse carrier
// - carrier high during reception blocks receive clock
// - transmitter runs with clear-to-send low; current character finishes
// - terminal ready output inverse of command bit one
// - request send output inverse of command bit five
// - break flag high on break, low after one clock of mark
// - jam sync pulse synchronises receiver at next receive clock edge
// - data address reads receive holding, writes transmit holding
`timescale 1ns/1ps
module upic_top #(
  parameter int DIV_WIDTH = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire upic_pkg::upic_cpu_t cpu,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [DIV_WIDTH-1:0] baud_divisor,
  input wire logic baud_generator_clock,
  input wire upic_pkg::upic_modem_t modem,
  input wire logic rx_data,
  output logic tx_data,
  input wire logic rx_pin_in,
  output logic rx_pin_out,
  output logic rx_pin_oe,
  input wire logic tx_pin_in,
  output logic tx_pin_out,
  output logic tx_pin_oe,
  output logic transmit_holding_free_n_oe,
  output logic receive_holding_full_n_oe,
  output logic transmit_empty_or_modem_change_n_oe,
  output logic terminal_ready_n,
  output logic request_send_n
);
  import upic_pkg::*;

  initial
  begin
    if (DIV_WIDTH < 2) $error("divider width too small");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] mode1, next_mode1;
  logic [7:0] mode2, next_mode2;
  logic [7:0] command, next_command;
  logic mode_ptr, next_mode_ptr;
  logic configured, next_configured;
  logic [7:0] transmit_holding_register, next_thr;
  logic thr_full, next_thr_full;
  logic [7:0] receive_holding_register, next_rhr;
  logic rhr_full, next_rhr_full;
  logic tx_empty, next_tx_empty;
  logic modem_change, next_modem_change;
  logic cs_prev, next_cs_prev;
  logic [1:0] modem_prev, next_modem_prev;
  logic rx_clk_prev, tx_clk_prev;
  logic [7:0] next_data_out;
  upic_tx_state_t tx_state, next_tx_state;
  logic [8:0] tx_shift, next_tx_shift;
  logic [3:0] tx_cnt, next_tx_cnt;
  logic tx_line, next_tx_line;
  upic_rx_state_t rx_state, next_rx_state;
  logic [7:0] rx_shift, next_rx_shift;
  logic [3:0] rx_cnt, next_rx_cnt;
  logic break_flag, next_break_flag;
  logic rx_all_zero, next_rx_all_zero;
  logic jam_prev, next_jam_prev, jam_pend, next_jam_pend;

  // decoded controls
  logic tx_en, rx_en, rx_ext, tx_ext, access, rd_strobe, wr_strobe;
  logic rx_tick, tx_tick, rx_int_tick, tx_int_tick, rx_int_lvl, tx_int_lvl;
  logic [5:0] mult;
  logic [7:0] status;

  // multiplier select shared by both dividers
  function automatic logic [5:0] mult_of(input logic [1:0] sel);
    unique case (sel)
      2'h2: mult_of = DIV_16X;
      2'h3: mult_of = DIV_64X;
      default: mult_of = DIV_1X;
    endcase
  endfunction : mult_of

  assign tx_en = command[COMMAND_BIT_TX_ENABLE] & configured;
  assign rx_en = command[COMMAND_BIT_RX_ENABLE] & configured;
  assign rx_ext = mode2[MODE2_RX_EXT];
  assign tx_ext = mode2[MODE2_TX_EXT];
  assign mult = mult_of(mode1[MODE1_MULT_LO +: 2]);
  assign access = ~cpu.chip_select_n;
  assign rd_strobe = access & cs_prev & ~cpu.write_not_read;
  assign wr_strobe = access & cs_prev & cpu.write_not_read;

  // ---------------------------------------------------------------
  // internal baud generators, only used for internal clocks
  // ---------------------------------------------------------------
  upic_tick #(.WIDTH(DIV_WIDTH)) u_rx_gen (
    .clk(clk),
    .srst(srst),
    .ce(ce & baud_generator_clock),
    .run(rx_en & ~rx_ext),
    .divisor(baud_divisor),
    .mult(mult),
    .bit_tick(rx_int_tick),
    .clk_level(rx_int_lvl)
  );
  upic_tick #(.WIDTH(DIV_WIDTH)) u_tx_gen (
    .clk(clk),
    .srst(srst),
    .ce(ce & baud_generator_clock),
    .run(tx_en & ~tx_ext),
    .divisor(baud_divisor),
    .mult(mult),
    .bit_tick(tx_int_tick),
    .clk_level(tx_int_lvl)
  );

  // external clocks: receive on rising, transmit on falling edge
  assign rx_tick = ~modem.carrier_n & (rx_ext ? (rx_pin_in & ~rx_clk_prev) : rx_int_tick);
  assign tx_tick = tx_ext ? (~tx_pin_in & tx_clk_prev) : tx_int_tick;

  // status byte assembly
  always_comb
  begin
    status = RESET_BYTE;
    status[STATUS_BIT_TX_FREE] = tx_en & ~thr_full;
    status[STATUS_BIT_RX_FULL] = rhr_full;
    status[STATUS_BIT_EMPTY_OR_CHANGE] = (tx_en & tx_empty) | modem_change;
    status[STATUS_BIT_CARRIER] = ~modem.carrier_n;
    status[STATUS_BIT_SET_READY] = ~modem.set_ready_n;
  end

  // ---------------------------------------------------------------
  // cpu port and flags
  // ---------------------------------------------------------------
  always_comb
  begin
    next_mode1 = mode1;
    next_mode2 = mode2;
    next_command = command;
    next_mode_ptr = mode_ptr;
    next_configured = configured;
    next_thr = transmit_holding_register;
    next_thr_full = thr_full;
    next_modem_change = modem_change;
    next_data_out = data_out;
    next_cs_prev = ~access;
    next_modem_prev = {modem.set_ready_n, modem.carrier_n};
    if (rd_strobe)
    begin
      unique case (cpu.addr)
        ADDR_DATA: next_data_out = receive_holding_register;
        ADDR_STATUS:
        begin
          next_data_out = status;
          next_modem_change = 1'b0;
        end
        ADDR_MODE:
        begin
          next_data_out = mode_ptr ? mode2 : mode1;
          next_mode_ptr = ~mode_ptr;
        end
        ADDR_COMMAND:
        begin
          next_data_out = command;
          next_mode_ptr = 1'b0;
        end
      endcase
    end
    if (wr_strobe)
    begin
      unique case (cpu.addr)
        ADDR_DATA:
        begin
          next_thr = cpu.data;
          next_thr_full = 1'b1;
        end
        ADDR_STATUS: next_thr = transmit_holding_register;
        ADDR_MODE:
        begin
          if (mode_ptr)
            next_mode2 = cpu.data;
          else
            next_mode1 = cpu.data;
          next_mode_ptr = ~mode_ptr;
        end
        ADDR_COMMAND:
        begin
          next_command = cpu.data;
          next_configured = 1'b1;
        end
      endcase
    end
    // load into shifter frees the holding register
    if (tx_state == TX_IDLE && thr_full && tx_tick && tx_en && !modem.clear_send_n)
      next_thr_full = 1'b0;
    if (wr_strobe && cpu.addr == ADDR_DATA)
      next_thr_full = 1'b1;
    // modem change set wins over status read clear
    if ((command[COMMAND_BIT_RX_ENABLE] | command[COMMAND_BIT_TX_ENABLE]) &&
        (next_modem_prev != modem_prev))
      next_modem_change = 1'b1;
  end

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  always_comb
  begin
    next_tx_state = tx_state;
    next_tx_shift = tx_shift;
    next_tx_cnt = tx_cnt;
    next_tx_line = tx_line;
    next_tx_empty = tx_empty;
    if (wr_strobe && cpu.addr == ADDR_DATA)
      next_tx_empty = 1'b0;
    if (!tx_en)
    begin
      next_tx_state = TX_IDLE;
      next_tx_line = 1'b1;
    end
    else if (tx_tick)
    begin
      unique case (tx_state)
        TX_IDLE:
        begin
          next_tx_line = 1'b1;
          if (thr_full && !modem.clear_send_n)
          begin
            next_tx_shift = {1'b1, transmit_holding_register};
            next_tx_line = 1'b0;
            next_tx_cnt = '0;
            next_tx_state = TX_SHIFT;
          end
        end
        TX_SHIFT:
        begin
          next_tx_line = tx_shift[0];
          next_tx_shift = {1'b1, tx_shift[8:1]};
          next_tx_cnt = tx_cnt + 4'h1;
          if (tx_cnt == DATA_BITS - 4'h1)
            next_tx_state = TX_STOP;
        end
        TX_STOP:
        begin
          next_tx_line = 1'b1;
          next_tx_state = TX_IDLE;
          if (!thr_full)
            next_tx_empty = 1'b1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  always_comb
  begin
    next_rx_state = rx_state;
    next_rx_shift = rx_shift;
    next_rx_cnt = rx_cnt;
    next_rhr = receive_holding_register;
    next_rhr_full = rhr_full;
    next_break_flag = break_flag;
    next_rx_all_zero = rx_all_zero;
    next_jam_prev = tx_pin_in;
    next_jam_pend = jam_pend;
    if (mode2[MODE2_TX_PIN_SYNC] && tx_pin_in && !jam_prev)
      next_jam_pend = 1'b1;
    if (rd_strobe && cpu.addr == ADDR_DATA)
      next_rhr_full = 1'b0;
    if (!rx_en)
    begin
      next_rx_state = RX_HUNT;
      next_rhr_full = 1'b0;
    end
    else if (rx_tick)
    begin
      if (break_flag && rx_data)
        next_break_flag = 1'b0;
      unique case (rx_state)
        RX_HUNT:
          if (jam_pend || (!rx_data && !break_flag))
          begin
            next_jam_pend = 1'b0;
            next_rx_cnt = '0;
            next_rx_all_zero = ~rx_data;
            next_rx_state = RX_SHIFT;
          end
        RX_SHIFT:
        begin
          next_rx_shift = {rx_data, rx_shift[7:1]};
          next_rx_all_zero = rx_all_zero & ~rx_data;
          next_rx_cnt = rx_cnt + 4'h1;
          if (rx_cnt == DATA_BITS - 4'h1)
            next_rx_state = RX_STOP;
        end
        RX_STOP:
        begin
          next_rhr = rx_shift;
          next_rhr_full = 1'b1;
          if (rx_all_zero && !rx_data)
            next_break_flag = 1'b1;
          next_rx_state = RX_HUNT;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers; reset returns every register to its idle value
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mode1 <= RESET_BYTE;
      mode2 <= RESET_BYTE;
      command <= RESET_BYTE;
      mode_ptr <= 1'b0;
      configured <= 1'b0;
      transmit_holding_register <= RESET_BYTE;
      thr_full <= 1'b0;
      receive_holding_register <= RESET_BYTE;
      rhr_full <= 1'b0;
      tx_empty <= 1'b0;
      modem_change <= 1'b0;
      cs_prev <= 1'b1;
      modem_prev <= 2'h3;
      rx_clk_prev <= 1'b0;
      tx_clk_prev <= 1'b0;
      data_out <= RESET_BYTE;
      tx_state <= TX_IDLE;
      tx_shift <= 9'h1ff;
      tx_cnt <= 4'h0;
      tx_line <= 1'b1;
      rx_state <= RX_HUNT;
      rx_shift <= RESET_BYTE;
      rx_cnt <= 4'h0;
      break_flag <= 1'b0;
      rx_all_zero <= 1'b0;
      jam_prev <= 1'b0;
      jam_pend <= 1'b0;
    end
    else if (ce)
    begin
      mode1 <= next_mode1;
      mode2 <= next_mode2;
      command <= next_command;
      mode_ptr <= next_mode_ptr;
      configured <= next_configured;
      transmit_holding_register <= next_thr;
      thr_full <= next_thr_full;
      receive_holding_register <= next_rhr;
      rhr_full <= next_rhr_full;
      tx_empty <= next_tx_empty;
      modem_change <= next_modem_change;
      cs_prev <= next_cs_prev;
      modem_prev <= next_modem_prev;
      rx_clk_prev <= rx_pin_in;
      tx_clk_prev <= tx_pin_in;
      data_out <= next_data_out;
      tx_state <= next_tx_state;
      tx_shift <= next_tx_shift;
      tx_cnt <= next_tx_cnt;
      tx_line <= next_tx_line;
      rx_state <= next_rx_state;
      rx_shift <= next_rx_shift;
      rx_cnt <= next_rx_cnt;
      break_flag <= next_break_flag;
      rx_all_zero <= next_rx_all_zero;
      jam_prev <= next_jam_prev;
      jam_pend <= next_jam_pend;
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  assign data_oe = access & ~cpu.write_not_read;
  assign tx_data = tx_line;
  assign rx_pin_oe = ~rx_ext;
  assign rx_pin_out = mode2[MODE2_RX_PIN_BREAK] ? break_flag : rx_int_lvl;
  assign tx_pin_oe = ~tx_ext & ~mode2[MODE2_TX_PIN_SYNC];
  assign tx_pin_out = tx_int_lvl;
  // open-drain: enable high pulls the line low
  assign transmit_holding_free_n_oe = status[STATUS_BIT_TX_FREE];
  assign receive_holding_full_n_oe = status[STATUS_BIT_RX_FULL];
  assign transmit_empty_or_modem_change_n_oe = status[STATUS_BIT_EMPTY_OR_CHANGE];
  assign terminal_ready_n = ~command[COMMAND_BIT_TERMINAL_READY];
  assign request_send_n = ~command[COMMAND_BIT_REQUEST_SEND];
endmodule : upic_top

/* File: hdl/upic_pkg.sv */
// package: constants, types and field positions for the serial pin block
package upic_pkg;
  // ---------------------------------------------------------------
  // register selects (addr1, addr0)
  // ---------------------------------------------------------------
  localparam logic [1:0] ADDR_DATA = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_MODE = 2'h2;
  localparam logic [1:0] ADDR_COMMAND = 2'h3;
  // ---------------------------------------------------------------
  // status and command bit positions
  // ---------------------------------------------------------------
  localparam int STATUS_BIT_TX_FREE = 0;
  localparam int STATUS_BIT_RX_FULL = 1;
  localparam int STATUS_BIT_EMPTY_OR_CHANGE = 2;
  localparam int STATUS_BIT_CARRIER = 6;
  localparam int STATUS_BIT_SET_READY = 7;
  localparam int COMMAND_BIT_TX_ENABLE = 0;
  localparam int COMMAND_BIT_TERMINAL_READY = 1;
  localparam int COMMAND_BIT_RX_ENABLE = 2;
  localparam int COMMAND_BIT_REQUEST_SEND = 5;
  // mode 2 fields: clock source selects and pin roles
  localparam int MODE2_TX_EXT = 4;
  localparam int MODE2_RX_EXT = 5;
  localparam int MODE2_TX_PIN_SYNC = 6;
  localparam int MODE2_RX_PIN_BREAK = 7;
  // mode 1 field: clock multiplier (1=1x, 2=16x, 3=64x)
  localparam int MODE1_MULT_LO = 0;
  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [5:0] DIV_1X = 6'h00;
  localparam logic [5:0] DIV_16X = 6'h0f;
  localparam logic [5:0] DIV_64X = 6'h3f;
  localparam logic [15:0] BAUD_DIV_RESET = 16'h0000;

  // cpu port bundle
  typedef struct packed {
    logic chip_select_n;
    logic write_not_read;
    logic [1:0] addr;
    logic [7:0] data;
  } upic_cpu_t;

  // modem inputs
  typedef struct packed {
    logic set_ready_n;
    logic carrier_n;
    logic clear_send_n;
  } upic_modem_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SHIFT = 3'b010,
    TX_STOP = 3'b100
  } upic_tx_state_t;

  typedef enum logic [2:0] {
    RX_HUNT = 3'b001,
    RX_SHIFT = 3'b010,
    RX_STOP = 3'b100
  } upic_rx_state_t;
endpackage : upic_pkg

/* File: hdl/upic_tick.sv */
// module: clock tick generator with divide-by-multiplier and edge pulses
`timescale 1ns/1ps
module upic_tick #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic run,
  input wire logic [WIDTH-1:0] divisor,
  input wire logic [5:0] mult,
  output logic bit_tick,
  output logic clk_level
);
  import upic_pkg::*;

  initial
  begin
    if (WIDTH < 2) $error("upic_tick width too small");
  end

  logic [WIDTH-1:0] base_cnt;
  logic [WIDTH-1:0] next_base_cnt;
  logic [5:0] mult_cnt;
  logic [5:0] next_mult_cnt;
  logic next_bit_tick;
  logic next_clk_level;

  // ---------------------------------------------------------------
  // counters: base divider then multiplier divider
  // ---------------------------------------------------------------
  always_comb
  begin
    next_base_cnt = base_cnt;
    next_mult_cnt = mult_cnt;
    next_bit_tick = 1'b0;
    next_clk_level = clk_level;
    if (!run)
    begin
      next_base_cnt = '0;
      next_mult_cnt = '0;
    end
    else if (base_cnt >= divisor)
    begin
      next_base_cnt = '0;
      next_clk_level = ~clk_level;
      if (mult_cnt >= mult)
      begin
        next_mult_cnt = '0;
        next_bit_tick = 1'b1;
      end
      else
        next_mult_cnt = mult_cnt + 6'h01;
    end
    else
      next_base_cnt = base_cnt + {{(WIDTH-1){1'b0}}, 1'b1};
  end

  // registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      base_cnt <= '0;
      mult_cnt <= '0;
      bit_tick <= 1'b0;
      clk_level <= 1'b0;
    end
    else if (ce)
    begin
      base_cnt <= next_base_cnt;
      mult_cnt <= next_mult_cnt;
      bit_tick <= next_bit_tick;
      clk_level <= next_clk_level;
    end
  end
endmodule : upic_tick

/* File: dv/upic_props.sv */
// checker: port-level properties of the serial pin block
`timescale 1ns/1ps
module upic_props
  import upic_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire upic_pkg::upic_cpu_t cpu,
  input wire logic data_oe,
  input wire upic_pkg::upic_modem_t modem,
  input wire logic tx_data,
  input wire logic transmit_holding_free_n_oe,
  input wire logic receive_holding_full_n_oe,
  input wire logic transmit_empty_or_modem_change_n_oe,
  input wire logic terminal_ready_n,
  input wire logic request_send_n
);
  // ------------------------------------------------------------
  // access decode and command mirror
  // ------------------------------------------------------------
  logic cs_q, tx_en_q, rx_en_q, cmd_seen;
  logic stb, wr_cmd, wr_dat, rd_dat, rd_sts;
  assign stb = ce && !cpu.chip_select_n && cs_q;
  assign wr_cmd = stb && cpu.write_not_read && cpu.addr == ADDR_COMMAND;
  assign wr_dat = stb && cpu.write_not_read && cpu.addr == ADDR_DATA;
  assign rd_dat = stb && !cpu.write_not_read && cpu.addr == ADDR_DATA;
  assign rd_sts = stb && !cpu.write_not_read && cpu.addr == ADDR_STATUS;
  // previous chip-select level, strobe on its first low cycle, and enables
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cs_q <= 1'b1;
      tx_en_q <= 1'b0;
      rx_en_q <= 1'b0;
      cmd_seen <= 1'b0;
    end
    else if (ce)
    begin
      cs_q <= cpu.chip_select_n;
      if (wr_cmd)
      begin
        tx_en_q <= cpu.data[COMMAND_BIT_TX_ENABLE];
        rx_en_q <= cpu.data[COMMAND_BIT_RX_ENABLE];
        cmd_seen <= 1'b1;
      end
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  AST_RESET_IDLE: assert property (@(posedge clk) disable iff (srst) $fell(srst) |->
    tx_data && terminal_ready_n && request_send_n && !transmit_holding_free_n_oe
    && !receive_holding_full_n_oe && !transmit_empty_or_modem_change_n_oe)
    else $error("outputs not idle after reset");
  AST_IDLE_UNTIL_CMD: assert property (@(posedge clk) disable iff (srst)
    !cmd_seen |-> tx_data && !transmit_holding_free_n_oe)
    else $error("activity before command write");
  AST_BUS_DRIVE: assert property (@(posedge clk) disable iff (srst)
    data_oe == (!cpu.chip_select_n && !cpu.write_not_read))
    else $error("data bus drive mismatch");
  AST_MODEM_OUT_VALUE: assert property (@(posedge clk) disable iff (srst)
    wr_cmd |=> terminal_ready_n == !$past(cpu.data[1]) && request_send_n == !$past(cpu.data[5]))
    else $error("modem outputs do not follow command");
  AST_MARK_WHEN_OFF: assert property (@(posedge clk) disable iff (srst)
    !tx_en_q && !$past(tx_en_q) |-> tx_data)
    else $error("line not at mark while disabled");
  AST_FREE_NEEDS_EN: assert property (@(posedge clk) disable iff (srst)
    transmit_holding_free_n_oe |-> tx_en_q)
    else $error("transmit free without enable");
  AST_RX_READ_CLEARS: assert property (@(posedge clk) disable iff (srst)
    rd_dat |=> !receive_holding_full_n_oe)
    else $error("receive full not cleared by read");
  AST_CHANGE_FLAG: assert property (@(posedge clk) disable iff (srst)
    !$stable({modem.set_ready_n, modem.carrier_n}) && (tx_en_q || rx_en_q)
    |-> ##[1:6] transmit_empty_or_modem_change_n_oe)
    else $error("modem change not flagged");
  AST_LOAD_RELEASES: assert property (@(posedge clk) disable iff (srst)
    wr_dat ##3 rd_sts |=> !transmit_empty_or_modem_change_n_oe)
    else $error("empty flag held after load and read");
endmodule : upic_props

bind upic_top upic_props u_upic_props (
  .clk(clk), .srst(srst), .ce(ce), .cpu(cpu), .data_oe(data_oe), .modem(modem),
  .tx_data(tx_data), .transmit_holding_free_n_oe(transmit_holding_free_n_oe),
  .receive_holding_full_n_oe(receive_holding_full_n_oe),
  .transmit_empty_or_modem_change_n_oe(transmit_empty_or_modem_change_n_oe),
  .terminal_ready_n(terminal_ready_n), .request_send_n(request_send_n)
);

/* File: dv/upic_line_model.sv */
// model: serial line equipment sending and receiving framed bytes
`timescale 1ns/1ps
module upic_line_model (
  input wire logic clk,
  input wire logic send,
  input wire logic [7:0] send_byte,
  input wire logic [7:0] bit_cycles,
  input wire logic tx_data,
  output logic rx_data,
  output logic [7:0] got_byte,
  output logic [7:0] got_cnt
);
  logic [9:0] frame;
  // line idles at mark
  initial
  begin
    rx_data = 1'b1;
    got_byte = 8'h00;
    got_cnt = 8'h00;
  end
  // frame sender: start, data lsb first, stop
  always @(posedge clk)
  begin
    if (send)
    begin
      frame = {1'b1, send_byte, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
        rx_data <= frame[i];
        repeat (bit_cycles) @(posedge clk);
      end
    end
  end
  // frame receiver: mid-bit sampling after the start edge
  always @(negedge tx_data)
  begin
    repeat (bit_cycles / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (bit_cycles) @(posedge clk);
      got_byte[i] = tx_data;
    end
    repeat (bit_cycles) @(posedge clk);
    got_cnt = got_cnt + 8'h01;
  end
endmodule : upic_line_model

/* File: dv/upic_top_test.sv */
// testbench: directed scenarios for the serial pin block
`timescale 1ns/1ps
module upic_top_test;
  import upic_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  upic_cpu_t cpu = '{1'b1, 1'b0, 2'h0, 8'h00};
  upic_modem_t modem = '{1'b0, 1'b0, 1'b0};
  logic send = 1'b0;
  logic [7:0] send_byte = 8'h00;
  logic [7:0] data_out, got_byte, got_cnt, rd;
  logic data_oe, rx_data, tx_data, rx_pin_out, rx_pin_oe, tx_pin_out, tx_pin_oe;
  logic free_oe, full_oe, empty_oe, terminal_ready_n, request_send_n;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  // clock pins pulled high when released
  wire logic rx_pin_in = rx_pin_oe ? rx_pin_out : 1'b1;
  wire logic tx_pin_in = tx_pin_oe ? tx_pin_out : 1'b1;

  upic_top u_upic_top (
    .clk(clk), .srst(srst), .ce(ce), .cpu(cpu), .data_out(data_out), .data_oe(data_oe),
    .baud_divisor(16'h0007), .baud_generator_clock(1'b1), .modem(modem),
    .rx_data(rx_data), .tx_data(tx_data), .rx_pin_in(rx_pin_in), .rx_pin_out(rx_pin_out),
    .rx_pin_oe(rx_pin_oe), .tx_pin_in(tx_pin_in), .tx_pin_out(tx_pin_out),
    .tx_pin_oe(tx_pin_oe), .transmit_holding_free_n_oe(free_oe),
    .receive_holding_full_n_oe(full_oe), .transmit_empty_or_modem_change_n_oe(empty_oe),
    .terminal_ready_n(terminal_ready_n), .request_send_n(request_send_n)
  );
  upic_line_model u_upic_line_model (
    .clk(clk), .send(send), .send_byte(send_byte), .bit_cycles(8'h08),
    .tx_data(tx_data), .rx_data(rx_data), .got_byte(got_byte), .got_cnt(got_cnt)
  );
  // ------------------------------------------------------------
  // clock, timeout and helpers
  // ------------------------------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one access: chip select low for two edges
  task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    cpu <= '{1'b0, w, a, d};
    repeat (2) @(posedge clk);
    cpu.chip_select_n <= 1'b1;
    #1 rd = data_out;
  endtask : acc
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task automatic line_send(input logic [7:0] b);
    @(posedge clk);
    send_byte <= b;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
  endtask : line_send
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_cmd();
    chk({tx_data, terminal_ready_n, request_send_n, free_oe, full_oe, empty_oe,
      rx_pin_oe, tx_pin_oe}, 8'he3);
    acc(1'b1, ADDR_COMMAND, 8'h22);
    acc(1'b0, ADDR_COMMAND, 8'h00);
    chk(rd, 8'h22);
    chk({6'h00, terminal_ready_n, request_send_n}, 8'h00);
    acc(1'b1, ADDR_COMMAND, 8'h00);
    chk({6'h00, terminal_ready_n, request_send_n}, 8'h03);
    acc(1'b1, ADDR_MODE, 8'h00);
    acc(1'b1, ADDR_MODE, 8'h30);
    acc(1'b0, ADDR_MODE, 8'h00);
    acc(1'b0, ADDR_MODE, 8'h00);
    chk(rd, 8'h30);
    chk({6'h00, rx_pin_oe, tx_pin_oe}, 8'h00);
    acc(1'b1, ADDR_MODE, 8'h00);
    acc(1'b1, ADDR_MODE, 8'h00);
    chk({6'h00, rx_pin_oe, tx_pin_oe}, 8'h03);
  endtask : t_reset_cmd
  task automatic t_dsr();
    acc(1'b1, ADDR_COMMAND, 8'h04);
    acc(1'b0, ADDR_STATUS, 8'h00);
    chk({7'h00, empty_oe}, 8'h00);
    @(posedge clk);
    modem.set_ready_n <= 1'b1;
    idle(6);
    chk({7'h00, empty_oe}, 8'h01);
    acc(1'b0, ADDR_STATUS, 8'h00);
    chk(rd & 8'hc4, 8'h44);
    chk({7'h00, empty_oe}, 8'h00);
  endtask : t_dsr
  task automatic t_tx();
    logic [7:0] c;
    @(posedge clk);
    modem.clear_send_n <= 1'b1;
    acc(1'b1, ADDR_COMMAND, 8'h01);
    chk({7'h00, free_oe}, 8'h01);
    acc(1'b1, ADDR_DATA, 8'ha5);
    acc(1'b0, ADDR_STATUS, 8'h00);
    chk({6'h00, free_oe, empty_oe}, 8'h00);
    idle(40);
    chk({7'h00, tx_data}, 8'h01);
    c = got_cnt;
    @(posedge clk);
    modem.clear_send_n <= 1'b0;
    for (int i = 0; i < 400 && got_cnt == c; i++)
      @(posedge clk);
    chk(got_byte, 8'ha5);
    idle(20);
    chk({6'h00, free_oe, empty_oe}, 8'h03);
    acc(1'b0, ADDR_STATUS, 8'h00);
    chk(rd & 8'h07, 8'h05);
    chk({7'h00, empty_oe}, 8'h01);
    acc(1'b1, ADDR_COMMAND, 8'h00);
    chk({6'h00, free_oe, tx_data}, 8'h01);
  endtask : t_tx
  task automatic t_rx();
    acc(1'b1, ADDR_COMMAND, 8'h04);
    line_send(8'h3c);
    for (int i = 0; i < 300 && !full_oe; i++)
      @(posedge clk);
    acc(1'b0, ADDR_DATA, 8'h00);
    chk(rd, 8'h3c);
    chk({7'h00, full_oe}, 8'h00);
    @(posedge clk);
    modem.carrier_n <= 1'b1;
    line_send(8'h5a);
    idle(120);
    chk({7'h00, full_oe}, 8'h00);
    acc(1'b0, ADDR_STATUS, 8'h00);
    chk(rd & 8'h42, 8'h00);
  endtask : t_rx
  initial
  begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    idle(1);
    t_reset_cmd();
    t_dsr();
    t_tx();
    t_rx();
    finish_test();
  end
endmodule : upic_top_test
